//--- verilog/gpt_timer.sv
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module gpt_timer
  import gpt_pkg::*;
#(
  parameter int RTC_DIV = RTC_EDGES_PER_SEC
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        capA,
  input  wire logic        capB,
  output logic             pwmA,
  output logic             pwmB
);

  // half function from global config and mode register
  function automatic gpt_hmode_e half_mode(input logic [2:0] cfg, input logic [3:0] md);
    gpt_hmode_e m;
    m = HM_IDLE;
    if (cfg[2])
    begin
      if (md[MODE_AMS_BIT] && !md[MODE_CMS_BIT] && md[1:0] == MODE_PERIODIC)
        m = HM_PWM;                                                // [R12]
      else if (md[1:0] == MODE_CAPTURE)
        m = md[MODE_CMS_BIT] ? HM_ETIME : HM_ECOUNT;               // [R1] [R9]
      else if (md[1:0] == MODE_ONESHOT || md[1:0] == MODE_PERIODIC)
        m = HM_TIMER;                                              // [R18]
    end
    return m;
  endfunction

  // selected edge kind from event field
  function automatic logic edge_hit(input logic [1:0] evt, input logic r, input logic f);
    logic h;
    h = 1'b0;
    case (evt)
      EVT_RISE: h = r;
      EVT_FALL: h = f;
      EVT_BOTH: h = r | f;
      default:  h = 1'b0;
    endcase
    return h;
  endfunction

  logic        dWrite_q;
  logic        rdPend_q;
  logic [11:0] dAddr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic [2:0]  cfg_q;
  logic [3:0]  mode_q  [2];
  logic [15:0] ctl_q;
  logic [1:0]  en_q;
  logic [15:0] imr_q;
  logic [15:0] ris_q;
  logic [15:0] load_q  [2];
  logic [15:0] match_q [2];
  logic [7:0]  pre_q   [2];
  logic [7:0]  preCnt_q[2];
  logic [15:0] cnt_q   [2];
  logic [15:0] cap_q   [2];
  logic [15:0] rtcDiv_q;
  logic [1:0]  sync1_q;
  logic [1:0]  sync2_q;
  logic [1:0]  prev_q;
  logic [1:0]  pwmRaw_q;
  logic [1:0]  pwm_q;

  logic [15:0] cntD    [2];
  logic [7:0]  preD    [2];
  logic [15:0] capD    [2];
  logic [1:0]  pwmRawD;
  logic [1:0]  enClr;
  logic [15:0] irqSet;
  logic [31:0] c32D;
  logic [31:0] rdMux;
  logic [15:0] half16;

  // ahb address phase capture
  wire        addrPhase = hsel && htrans[1] && hready;
  wire        rdStart   = addrPhase && !hwrite;

  // write strobes for the data phase
  wire wCfg    = dWrite_q && dAddr_q == OFF_CFG;
  wire wModeA  = dWrite_q && dAddr_q == OFF_MODE_A;
  wire wModeB  = dWrite_q && dAddr_q == OFF_MODE_B;
  wire wCtl    = dWrite_q && dAddr_q == OFF_CTL;
  wire wImr    = dWrite_q && dAddr_q == OFF_IMR;
  wire wIcr    = dWrite_q && dAddr_q == OFF_ICR;
  wire wLoadA  = dWrite_q && dAddr_q == OFF_LOAD_A;
  wire wLoadB  = dWrite_q && dAddr_q == OFF_LOAD_B;
  wire wMatchA = dWrite_q && dAddr_q == OFF_MATCH_A;
  wire wMatchB = dWrite_q && dAddr_q == OFF_MATCH_B;
  wire wPreA   = dWrite_q && dAddr_q == OFF_PRE_A;
  wire wPreB   = dWrite_q && dAddr_q == OFF_PRE_B;

  // 32-bit views; in 32-bit configs load and match writes to half A also fill half B
  wire        wide     = !cfg_q[2];
  wire        wLoadHi  = wLoadB || (wide && wLoadA);
  wire        wMatchHi = wMatchB || (wide && wMatchA);
  wire [15:0] hiData   = wide ? hwdata[31:16] : hwdata[15:0];
  wire [31:0] c32      = {cnt_q[1], cnt_q[0]};
  wire [31:0] load32   = {load_q[1], load_q[0]};
  wire [31:0] match32  = {match_q[1], match_q[0]};
  wire [15:0] mis      = ris_q & imr_q;
  wire [15:0] icrMask  = wIcr ? hwdata[15:0] : 16'h0000;

  // half functions and edge detection from synchronised samples
  wire gpt_hmode_e hmA = half_mode(cfg_q, mode_q[0]);
  wire gpt_hmode_e hmB = half_mode(cfg_q, mode_q[1]);
  wire [1:0] rise = sync2_q & ~prev_q;                             // [R24]
  wire [1:0] fall = ~sync2_q & prev_q;                             // [R24]

  // rtc: capture pin edges divided down to one step a second
  wire rtcRun  = cfg_q == CFG_RTC && en_q[0] &&
                 (!ctl_q[CTL_STALL_BIT] || ctl_q[CTL_RTC_OVR_BIT]);
  wire rtcWrap = rtcDiv_q == 16'(RTC_DIV - 1);
  wire rtcStep = rtcRun && rise[0] && rtcWrap;

  // next state of both halves and of the 32-bit counter
  always_comb
  begin
    gpt_hmode_e hm;
    logic       stall;
    logic       hit;
    logic [15:0] dec;
    int          sh;
    hm = HM_IDLE;
    stall = 1'b0;
    hit = 1'b0;
    dec = 16'h0000;
    sh = 0;
    irqSet = 16'h0000;
    enClr = 2'b00;
    pwmRawD = pwmRaw_q;
    for (int i = 0; i < 2; i++)
    begin
      hm = (i == 0) ? hmA : hmB;
      sh = i * CTL_HALF_SHIFT;
      stall = ctl_q[sh + CTL_STALL_BIT];
      hit = edge_hit(ctl_q[sh + CTL_EVT_LSB +: 2], rise[i], fall[i]);
      dec = cnt_q[i] - 16'h0001;
      cntD[i] = cnt_q[i];
      preD[i] = preCnt_q[i];
      capD[i] = cap_q[i];
      unique case (hm)
        HM_TIMER, HM_PWM:
          if (en_q[i] && !stall)
          begin
            if (preCnt_q[i] != 8'h00)
              preD[i] = preCnt_q[i] - 8'h01;
            else
            begin
              preD[i] = pre_q[i];
              cntD[i] = (cnt_q[i] == 16'h0000) ? load_q[i] : dec;  // [R13]
              if (hm == HM_TIMER && cnt_q[i] == 16'h0000)
              begin
                irqSet[sh + IRQ_TO] = 1'b1;                        // [R23]
                enClr[i] = mode_q[i][1:0] == MODE_ONESHOT;         // [R18]
              end
            end
            if (hm == HM_PWM && cnt_q[i] == load_q[i])
              pwmRawD[i] = 1'b1;                                   // [R14]
            else if (hm == HM_PWM && cnt_q[i] == match_q[i])
              pwmRawD[i] = 1'b0;                                   // [R14]
          end
        HM_ECOUNT:
          if (en_q[i] && hit)                                      // [R6]
          begin
            if (dec == match_q[i])
            begin
              cntD[i] = load_q[i];                                 // [R5]
              irqSet[sh + IRQ_CM] = 1'b1;                          // [R4]
              enClr[i] = 1'b1;                                     // [R5]
            end
            else
              cntD[i] = dec;                                       // [R3]
          end
        HM_ETIME:
          if (en_q[i])
          begin
            // no prescale here: every clock counts
            cntD[i] = (cnt_q[i] == 16'h0000) ? load_q[i] : dec;    // [R7] [R8] [R11]
            if (hit)
            begin
              capD[i] = cnt_q[i];                                  // [R10]
              irqSet[sh + IRQ_CE] = 1'b1;                          // [R10]
            end
          end
        HM_IDLE: ;
      endcase
    end
    // 32-bit one-shot/periodic and rtc share the joined counter
    c32D = c32;
    if (cfg_q == CFG_32 && en_q[0] && !ctl_q[CTL_STALL_BIT])      // [R17]
    begin
      if (c32 == 32'h0000_0000)
      begin
        c32D = load32;
        irqSet[IRQ_TO] = 1'b1;
        enClr[0] = mode_q[0][1:0] == MODE_ONESHOT;                 // [R18]
      end
      else
        c32D = c32 - 32'h0000_0001;
    end
    else if (rtcStep)
    begin
      if (c32 == match32)
      begin
        c32D = RTC_WRAP;                                           // [R21]
        irqSet[IRQ_RTC] = 1'b1;
      end
      else
        c32D = c32 + 32'h0000_0001;
    end
    if (wide)
    begin
      cntD[0] = c32D[15:0];
      cntD[1] = c32D[31:16];
    end
    // software load takes effect on the next cycle
    if (wLoadA)
      cntD[0] = hwdata[15:0];
    if (wLoadHi)
      cntD[1] = hiData;
    if (wCfg && hwdata[2:0] == CFG_RTC)
    begin
      cntD[0] = RTC_FIRST[15:0];
      cntD[1] = RTC_FIRST[31:16];
    end
    if (wPreA)
      preD[0] = hwdata[7:0];
    if (wPreB)
      preD[1] = hwdata[7:0];
  end

  // value register: capture in edge time, joined in 32-bit configs
  assign half16 = (hmA == HM_ETIME) ? cap_q[0] : cnt_q[0];

  // register read selection, unmapped offsets read zero
  always_comb
  begin
    unique case (dAddr_q)
      OFF_CFG:     rdMux = {29'h0, cfg_q};
      OFF_MODE_A:  rdMux = {28'h0, mode_q[0]};
      OFF_MODE_B:  rdMux = {28'h0, mode_q[1]};
      OFF_CTL:     rdMux = {16'h0, ctl_q[15:9], en_q[1], ctl_q[7:1], en_q[0]};
      OFF_IMR:     rdMux = {16'h0, imr_q};
      OFF_RIS:     rdMux = {16'h0, ris_q};
      OFF_MIS:     rdMux = {16'h0, mis};                           // [R4] [R10]
      OFF_LOAD_A:  rdMux = wide ? load32 : {16'h0, load_q[0]};
      OFF_LOAD_B:  rdMux = {16'h0, load_q[1]};
      OFF_MATCH_A: rdMux = wide ? match32 : {16'h0, match_q[0]};
      OFF_MATCH_B: rdMux = {16'h0, match_q[1]};
      OFF_PRE_A:   rdMux = {24'h0, pre_q[0]};
      OFF_PRE_B:   rdMux = {24'h0, pre_q[1]};
      OFF_VAL_A:   rdMux = wide ? c32 : {16'h0, half16};           // [R10]
      OFF_VAL_B:   rdMux = {16'h0, (hmB == HM_ETIME) ? cap_q[1] : cnt_q[1]};
      default:     rdMux = 32'h0000_0000;
    endcase
  end

  // ahb slave: writes zero-wait, reads one wait state so data is fresh
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dWrite_q    <= 1'b0;
      rdPend_q    <= 1'b0;
      dAddr_q     <= 12'h000;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      dWrite_q    <= addrPhase && hwrite;
      rdPend_q    <= rdStart;
      hreadyout_q <= !rdStart;
      if (addrPhase)
        dAddr_q <= haddr[11:0];
      if (rdPend_q)
        hrdata_q <= rdMux;
    end
  end

  // configuration registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cfg_q     <= CFG_32;
      mode_q[0] <= 4'h0;
      mode_q[1] <= 4'h0;
      ctl_q     <= 16'h0000;
      imr_q     <= 16'h0000;
    end
    else
    begin
      if (wCfg)
        cfg_q <= hwdata[2:0];                                      // [R17]
      if (wModeA)
        mode_q[0] <= hwdata[3:0];
      if (wModeB)
        mode_q[1] <= hwdata[3:0];
      if (wCtl)
        ctl_q <= hwdata[15:0];
      if (wImr)
        imr_q <= hwdata[15:0];
    end
  end

  // enables: software write wins over the hardware stop
  always_ff @(posedge clock)
  begin
    if (srst)
      en_q <= 2'b00;
    else if (wCtl)
      en_q <= {hwdata[CTL_HALF_SHIFT + CTL_EN_BIT], hwdata[CTL_EN_BIT]};
    else
      en_q <= en_q & ~enClr;                                       // [R5]
  end

  // raw status: a set in the clearing cycle survives
  always_ff @(posedge clock)
  begin
    if (srst)
      ris_q <= 16'h0000;
    else
      ris_q <= (ris_q & ~icrMask) | irqSet;                        // [R22]
  end

  // load, match and prescale values
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      load_q  <= '{LOAD_RST, LOAD_RST};                            // [R8]
      match_q <= '{MATCH_RST, MATCH_RST};
      pre_q   <= '{PRE_RST, PRE_RST};
    end
    else
    begin
      if (wLoadA)
        load_q[0] <= hwdata[15:0];
      if (wLoadHi)
        load_q[1] <= hiData;
      if (wMatchA)
        match_q[0] <= hwdata[15:0];
      if (wMatchHi)
        match_q[1] <= hiData;
      if (wPreA)
        pre_q[0] <= hwdata[7:0];
      if (wPreB)
        pre_q[1] <= hwdata[7:0];
    end
  end

  // counters, captures and pwm outputs
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cnt_q    <= '{LOAD_RST, LOAD_RST};
      preCnt_q <= '{PRE_RST, PRE_RST};
      cap_q    <= '{LOAD_RST, LOAD_RST};
      pwmRaw_q <= 2'b00;
      pwm_q    <= 2'b00;
    end
    else
    begin
      cnt_q    <= cntD;
      preCnt_q <= preD;
      cap_q    <= capD;
      pwmRaw_q <= pwmRawD;
      pwm_q    <= pwmRawD ^ {ctl_q[CTL_HALF_SHIFT + CTL_PWMINV_BIT],
                             ctl_q[CTL_PWMINV_BIT]};               // [R15]
    end
  end

  // pin synchroniser; the first stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sync1_q  <= 2'b00;
      sync2_q  <= 2'b00;
      prev_q   <= 2'b00;
      rtcDiv_q <= 16'h0000;
    end
    else
    begin
      sync1_q <= {capB, capA};                                     // [R24]
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      if (!rtcRun)
        rtcDiv_q <= 16'h0000;
      else if (rise[0])
        rtcDiv_q <= rtcWrap ? 16'h0000 : rtcDiv_q + 16'h0001;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;
  assign pwmA      = pwm_q[0];
  assign pwmB      = pwm_q[1];

  // checks on counting, capture, pwm and flag behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  wire quietA = !dWrite_q;
  wire ecA    = hmA == HM_ECOUNT;

  chk_count_step: assert property (ecA && en_q[0] && rise[0] && !fall[0] &&      // [R3]
      ctl_q[3:2] == EVT_RISE && cnt_q[0] - 16'h0001 != match_q[0] && quietA
      |=> cnt_q[0] == $past(cnt_q[0]) - 16'h0001)
    else $error("edge count did not step down by one");
  chk_match_flag: assert property (ecA && enClr[0] && quietA                     // [R4]
      |=> ris_q[IRQ_CM] && mis[IRQ_CM] == imr_q[IRQ_CM])
    else $error("count match flag not raised");
  chk_match_stop: assert property (ecA && enClr[0] && quietA                     // [R5]
      |=> !en_q[0] && cnt_q[0] == $past(load_q[0]))
    else $error("count match did not reload and stop");
  chk_ignore_edges: assert property (ecA && !en_q[0] && quietA                   // [R6]
      |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("stopped edge counter moved");
  chk_capture_value: assert property (hmB == HM_ETIME && en_q[1] &&              // [R10]
      irqSet[IRQ_HALF_SHIFT + IRQ_CE] |=> cap_q[1] == $past(cnt_q[1]) &&
      ris_q[IRQ_HALF_SHIFT + IRQ_CE])
    else $error("edge time capture wrong");
  chk_time_reload: assert property (hmB == HM_ETIME && en_q[1] &&                // [R11]
      cnt_q[1] == 16'h0000 && quietA |=> cnt_q[1] == $past(load_q[1]))
    else $error("edge time did not reload at zero");
  // a stalled pwm holds its level, so the antecedent requires stall to be clear
  chk_pwm_level: assert property (hmA == HM_PWM && en_q[0] && quietA &&          // [R14]
      !ctl_q[CTL_STALL_BIT] && cnt_q[0] == load_q[0] |=> pwmA == !ctl_q[CTL_PWMINV_BIT])
    else $error("pwm not asserted at load value");
  chk_pwm_noflag: assert property (hmA == HM_PWM && hmB == HM_PWM                // [R13]
      |-> irqSet == 16'h0000)
    else $error("pwm mode raised a flag");
  chk_rtc_wrap: assert property (rtcStep && c32 == match32 && quietA             // [R21]
      |=> c32 == RTC_WRAP && ris_q[IRQ_RTC])
    else $error("rtc did not wrap at match");
  chk_flag_clear: assert property (wIcr && hwdata[IRQ_TO] && !irqSet[IRQ_TO]     // [R22]
      |=> !ris_q[IRQ_TO] ##1 !mis[IRQ_TO] || ris_q[IRQ_TO])
    else $error("clear did not drop timeout flag");

  cov_count_done: cover property (ecA && enClr[0]);
  cov_capture: cover property (hmB == HM_ETIME && irqSet[IRQ_HALF_SHIFT + IRQ_CE]);
  cov_pwm_cycle: cover property (hmA == HM_PWM && pwmRawD[0] ##[1:200] !pwmRawD[0]);
  cov_rtc_wrap: cover property (rtcStep && c32 == match32);

endmodule

//--- verilog/gpt_pkg.sv
// Operation
// [R1] edge count mode: capture-mode bit 0, counts down on chosen edge kind
// [R2] software sets load minus match equal to the wanted edge count
// [R3] while enabled each chosen capture edge decrements the count by one
// [R4] reaching match sets raw count-match flag; masked copy follows the mask
// [R5] after a count match reload from load register and clear enable
// [R6] after count match every further edge is ignored until re-enabled
// [R7] edge time mode never uses the prescaler
// [R8] edge time mode free-runs down from load, load resets to ffff
// [R9] capture-mode bit 1 selects edge time; event field picks the edges
// [R10] chosen edge copies count to value register, sets capture-event flag
// [R11] edge time keeps running while enabled, reloads from load at zero
// [R12] pwm mode when alternate bit 1, capture bit 0, mode field 2
// [R13] pwm counts down, reloads after zero, repeats, sets no flags
// [R14] pwm output asserts at load value, deasserts at match value
// [R15] pwm-level invert bit flips the pwm output polarity
// [R16] software enables the timer clock gate before use
// [R17] config 0 is 32-bit timer, 1 is rtc, 4 is two 16-bit timers
// [R18] mode field 1 is one-shot, 2 is periodic
// [R19] software clears enable before reconfiguring, sets it last
// [R20] rtc needs a 32.768 kHz signal on the capture pin
// [R21] rtc count equal to match reloads zero and keeps counting
// [R22] writing 1 to the clear register clears the raw and masked flag
// [R23] 16-bit one-shot or periodic sets timeout flag on reaching zero
// [R24] capture pin is synchronised and edges found from successive samples
package gpt_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_CFG     = 12'h000;
  localparam logic [11:0] OFF_MODE_A  = 12'h004;
  localparam logic [11:0] OFF_MODE_B  = 12'h008;
  localparam logic [11:0] OFF_CTL     = 12'h00c;
  localparam logic [11:0] OFF_IMR     = 12'h018;
  localparam logic [11:0] OFF_RIS     = 12'h01c;
  localparam logic [11:0] OFF_MIS     = 12'h020;
  localparam logic [11:0] OFF_ICR     = 12'h024;
  localparam logic [11:0] OFF_LOAD_A  = 12'h028;
  localparam logic [11:0] OFF_LOAD_B  = 12'h02c;
  localparam logic [11:0] OFF_MATCH_A = 12'h030;
  localparam logic [11:0] OFF_MATCH_B = 12'h034;
  localparam logic [11:0] OFF_PRE_A   = 12'h038;
  localparam logic [11:0] OFF_PRE_B   = 12'h03c;
  localparam logic [11:0] OFF_VAL_A   = 12'h048;
  localparam logic [11:0] OFF_VAL_B   = 12'h04c;

  // global configuration codes
  localparam logic [2:0] CFG_32  = 3'h0;
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_16  = 3'h4;

  // half-timer mode register fields
  localparam logic [1:0] MODE_ONESHOT  = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE  = 2'h3;
  localparam int         MODE_CMS_BIT  = 2;
  localparam int         MODE_AMS_BIT  = 3;

  // control register fields, half B sits CTL_HALF_SHIFT above half A
  localparam int CTL_HALF_SHIFT  = 8;
  localparam int CTL_EN_BIT      = 0;
  localparam int CTL_STALL_BIT   = 1;
  localparam int CTL_EVT_LSB     = 2;
  localparam int CTL_RTC_OVR_BIT = 4;
  localparam int CTL_PWMINV_BIT  = 6;
  localparam logic [1:0] EVT_RISE = 2'h0;
  localparam logic [1:0] EVT_FALL = 2'h1;
  localparam logic [1:0] EVT_BOTH = 2'h3;

  // status, mask and clear bit positions
  localparam int IRQ_TO         = 0;
  localparam int IRQ_CM         = 1;
  localparam int IRQ_CE         = 2;
  localparam int IRQ_RTC        = 3;
  localparam int IRQ_HALF_SHIFT = 8;

  // reset and reload values
  localparam logic [15:0] LOAD_RST  = 16'hffff;
  localparam logic [15:0] MATCH_RST = 16'hffff;
  localparam logic [7:0]  PRE_RST   = 8'h00;
  localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
  localparam logic [31:0] RTC_WRAP  = 32'h0000_0000;
  localparam int          RTC_EDGES_PER_SEC = 32768;

  // operating function of one half
  typedef enum logic [2:0] {
    HM_IDLE   = 3'b000,
    HM_TIMER  = 3'b001,
    HM_ECOUNT = 3'b011,
    HM_ETIME  = 3'b010,
    HM_PWM    = 3'b110
  } gpt_hmode_e;

endpackage

//--- sim/gpt_pin_model.sv
`timescale 1ns/1ps
module gpt_pin_model (
  input  wire logic clock,
  output logic      capA,
  output logic      capB
);
  // pins idle low until a scenario drives edges
  initial
  begin
    capA = 1'b0;
    capB = 1'b0;
  end
  // each level holds gap clocks, well above the one-clock minimum pulse
  task automatic toggle(input bit half, input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      repeat (gap) @(posedge clock);
      if (half)
        capB <= ~capB;
      else
        capA <= ~capA;
    end
  endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import gpt_pkg::*;
  logic        clock, srst, hsel, hwrite, hreadyout, hresp, capA, capB, pwmA, pwmB;
  logic [1:0]  htrans, ev;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, lfsr, v1, expCnt;
  int          nMismatch, totalChecks, cyc, hi, hiB;

  gpt_timer #(.RTC_DIV(4)) dut_u (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capA(capA), .capB(capB),
    .pwmA(pwmA), .pwmB(pwmB));
  gpt_pin_model pinU (.clock(clock), .capA(capA), .capB(capB));

  // 25 MHz system clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // a hang ends the run as a mismatch
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      nMismatch++;
      end_sim();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // address phase held until hready is sampled high
  task automatic addr_ph(input logic [11:0] a, input logic w);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask

  // read data taken at the edge where hready is high again
  task automatic rdw(input logic [11:0] a, output logic [31:0] d);
    addr_ph(a, 1'b0);
    do @(posedge clock); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rdw(a, rd);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    srst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsize = 3'h2;
    cyc = 0;
    nMismatch = 0;
    totalChecks = 0;
    lfsr = 32'h5411f5bf;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rchk(OFF_LOAD_A, 32'hffffffff);
    rchk(OFF_CFG, 32'h0);
    rchk(12'h100, 32'h0);
    lfsr = nxt(lfsr);
    wr(OFF_LOAD_A, lfsr);
    rchk(OFF_LOAD_B, {16'h0, lfsr[31:16]});
    // edge count on half A, each event kind, software keeps enable for last
    wr(OFF_CFG, {29'h0, CFG_16});
    wr(OFF_MODE_A, {30'h0, MODE_CAPTURE});
    lfsr = nxt(lfsr);
    expCnt = 32'h10 + {24'h0, lfsr[7:0]};
    wr(OFF_MATCH_A, expCnt - 6); // six edges wanted
    wr(OFF_IMR, 32'h2);
    for (int e = 0; e < 3; e++)
    begin
      ev = (e == 2) ? EVT_BOTH : e[1:0];
      wr(OFF_CTL, {28'h0, ev, 2'h0});
      wr(OFF_LOAD_A, expCnt);
      wr(OFF_CTL, {28'h0, ev, 2'h1});
      pinU.toggle(0, 4, 4);
      repeat (6) @(posedge clock); // pin sync delay
      rchk(OFF_VAL_A, expCnt - ((ev == EVT_BOTH) ? 4 : 2));
    end
    pinU.toggle(0, 2, 4);
    repeat (6) @(posedge clock);
    rchk(OFF_RIS, 32'h2);
    rchk(OFF_MIS, 32'h2);
    rchk(OFF_CTL, 32'hc);
    rchk(OFF_VAL_A, expCnt);
    pinU.toggle(0, 2, 4);
    repeat (6) @(posedge clock);
    rchk(OFF_VAL_A, expCnt);
    wr(OFF_ICR, 32'h2);
    rchk(OFF_RIS, 32'h0);
    rchk(OFF_MIS, 32'h0);
    // edge time on half B, prescale set so that using it would show
    wr(OFF_MODE_B, 32'h7);
    wr(OFF_PRE_B, 32'h5);
    wr(OFF_CTL, 32'h100);
    fork
      pinU.toggle(1, 3, 40);
    join_none
    repeat (50) @(posedge clock);
    rdw(OFF_VAL_B, v1);
    repeat (100) @(posedge clock);
    rchk(OFF_VAL_B, v1 - 80); // rises 80 clocks apart
    rchk(OFF_RIS, 32'h400);
    // small start value: without a reload at zero the capture would read high
    wr(OFF_LOAD_B, 32'h20);
    pinU.toggle(1, 2, 40);
    repeat (6) @(posedge clock);
    rdw(OFF_VAL_B, rd);
    chk({31'h0, rd <= 32'h20}, 32'h1);
    // pwm on both halves, plain then inverted; 10-cycle period, 6 high
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h70f);
    wr(OFF_PRE_B, 32'h0);
    for (int h = 0; h < 2; h++)
    begin
      wr((h == 1) ? OFF_MODE_B : OFF_MODE_A, 32'ha);
      wr((h == 1) ? OFF_LOAD_B : OFF_LOAD_A, 32'h9);
      wr((h == 1) ? OFF_MATCH_B : OFF_MATCH_A, 32'h3);
    end
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(OFF_CTL, (inv == 1) ? 32'h4141 : 32'h101);
      repeat (30) @(posedge clock);
      hi = 0;
      hiB = 0;
      repeat (40)
      begin
        @(posedge clock);
        hi += (pwmA === 1'b1);
        hiB += (pwmB === 1'b1);
      end
      chk(32'(hi), (inv == 1) ? 32'd16 : 32'd24);
      chk(32'(hiB), (inv == 1) ? 32'd16 : 32'd24);
    end
    rchk(OFF_RIS, 32'h0);
    // half B one-shot then periodic timeout
    for (int m = 1; m < 3; m++)
    begin
      wr(OFF_CTL, 32'h0);
      wr(OFF_MODE_B, 32'(m));
      wr(OFF_LOAD_B, 32'h8);
      wr(OFF_ICR, 32'h100);
      wr(OFF_CTL, 32'h100);
      repeat (80) @(posedge clock);
      rchk(OFF_RIS, 32'h100);
      rchk(OFF_CTL, (m == 1) ? 32'h0 : 32'h100);
    end
    // rtc: four rising capA edges per step, match at 3
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h70f);
    wr(OFF_CFG, {29'h0, CFG_RTC});
    wr(OFF_MATCH_A, 32'h3);
    wr(OFF_IMR, 32'h8);
    wr(OFF_CTL, 32'h1);
    pinU.toggle(0, 24, 2); // slow clock on capA
    repeat (6) @(posedge clock);
    rchk(OFF_MIS, 32'h8);
    rdw(OFF_VAL_A, rd);
    chk({31'h0, rd < 32'h4}, 32'h1); // count wrapped past match
    end_sim();
  end
endmodule
